//--- hdl/wssp_slave.v
// Serial host slave port: command decode, data, status and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "wssp_defines.vh"

module wssp_slave #(
    parameter [31:0] P_PATTERN = `WSSP_PATTERN
) (
    input  wire        i_clk_sys,
    input  wire        i_rst,
    input  wire        i_serial_clock_pin,
    input  wire        i_data3_cs_n,
    input  wire        i_cmd_sdi,
    output reg         o_data0_sdo,
    output reg         o_data0_oe,
    output reg         o_data1_irq,
    output reg         o_wakeup,
    output reg         o_wr_valid,
    output reg  [1:0]  o_wr_func,
    output reg  [16:0] o_wr_addr,
    output reg  [7:0]  o_wr_data,
    input  wire        i_wr_full,
    output reg         o_rd_req,
    output reg  [1:0]  o_rd_func,
    output reg  [16:0] o_rd_addr,
    input  wire [7:0]  i_rd_data,
    input  wire        i_rd_avail,
    input  wire        i_chan_irq,
    input  wire        i_pkt_fifo_empty,
    input  wire        i_pkt_waiting,
    input  wire [10:0] i_pkt_len
);

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_CMD  = 5'h02;
    localparam [4:0] S_DATA = 5'h04;
    localparam [4:0] S_STAT = 5'h08;
    localparam [4:0] S_DONE = 5'h10;

    // Byte lane of the k-th byte of a unit in address order
    function [1:0] wssp_bidx;
        input       w32;
        input       big;
        input [1:0] k;
        begin
            if (big)
                wssp_bidx = (w32 ? 2'h3 : 2'h1) - k;
            else
                wssp_bidx = k;
        end
    endfunction

    // ************************************************************
    // Pin sampling
    // ************************************************************
    // The serial clock is oversampled, so it must stay well below
    // a quarter of the system clock rate.
    wire [2:0] sync_q;
    wire       sclk_s = sync_q[2];
    wire       cs_s   = sync_q[1];
    wire       sdi_s  = sync_q[0];

    wssp_sync #(
        .P_W   (3),
        .P_RST (3'h2)
    ) u_sync (
        .i_clk (i_clk_sys),
        .i_rst (i_rst),
        .i_d   ({i_serial_clock_pin, i_data3_cs_n, i_cmd_sdi}),
        .o_q   (sync_q)
    );

    reg        sclk_d_reg;
    reg        cs_d_reg;
    reg        rise_d_reg;
    reg [4:0]  state_reg;
    reg [4:0]  bit_cnt_reg;
    reg [31:0] sh_reg;
    reg        dir_reg;
    reg        inc_reg;
    reg [1:0]  func_reg;
    reg [16:0] ptr_reg;
    reg [11:0] byte_left_reg;
    reg [31:0] tx_unit_reg;
    reg [31:0] nxt_unit_reg;
    reg [31:0] em_unit_reg;
    reg [2:0]  em_cnt_reg;
    reg [1:0]  em_k_reg;
    reg [11:0] fe_left_reg;
    reg [2:0]  fe_cnt_reg;
    reg [1:0]  fe_k_reg;
    reg        fe_phase_reg;
    reg        wl_reg;
    reg        be_reg;
    reg        hs_reg;
    reg        pol_reg;
    reg        wake_reg;
    reg        sten_reg;
    reg        iws_reg;
    reg        dna_reg;
    reg        unf_reg;
    reg        ovf_reg;
    reg        bovf_reg;
    reg        x_dna_reg;
    reg        x_unf_reg;
    reg        x_ovf_reg;
    reg [7:0]  f0_rd;

    wire rise  = sclk_s & ~sclk_d_reg & ~cs_s;
    wire fall  = ~sclk_s & sclk_d_reg & ~cs_s;
    wire drive = hs_reg ? rise_d_reg : fall;
    wire cs_fall = ~cs_s & cs_d_reg;
    wire commit  = cs_s & ~cs_d_reg & (state_reg != S_IDLE)
                   & (state_reg != S_CMD);

    // ************************************************************
    // Command and unit arithmetic
    // ************************************************************
    wire [31:0] cmd_w   = {sh_reg[30:0], sdi_s};
    wire [31:0] early_w = {cmd_w[20:0], 11'h000};
    wire [10:0] len_f   = cmd_w[`WSSP_CMD_LN_HI:`WSSP_CMD_LN_LO];
    wire [11:0] tot_w   = (len_f == 11'h000) ? `WSSP_LEN_MAX
                          : {1'b0, len_f};
    wire [2:0]  nb      = wl_reg ? 3'h4 : 3'h2;
    wire [11:0] nb12    = {9'h000, nb};
    wire [4:0]  ub_last = wl_reg ? 5'h1f : 5'h0f;
    wire [11:0] rem0    = (tot_w > nb12) ? tot_w - nb12 : 12'h000;
    wire [11:0] take0   = (rem0 > nb12) ? nb12 : rem0;
    wire [11:0] fe_take = (fe_left_reg > nb12) ? nb12 : fe_left_reg;
    wire [11:0] em_take = (byte_left_reg > nb12) ? nb12 : byte_left_reg;
    wire [16:0] ptr_inc = ptr_reg + {16'h0000, inc_reg};

    wire [1:0] fe_i    = wssp_bidx(wl_reg, be_reg, fe_k_reg);
    wire [1:0] em_i    = wssp_bidx(wl_reg, be_reg, em_k_reg);
    wire [7:0] em_byte = em_unit_reg[{em_i, 3'h0} +: 8];
    wire       is_port = (func_reg == `WSSP_FN_PORT);
    wire [7:0] fe_byte = is_port ? f0_rd
                         : (i_rd_avail ? i_rd_data : 8'h00);

    // ************************************************************
    // Status word and interrupt source
    // ************************************************************
    wire [31:0] stat_w = {12'h000, i_pkt_len, i_pkt_waiting, 3'h0,
                          i_pkt_fifo_empty, i_chan_irq,
                          x_ovf_reg, x_unf_reg, x_dna_reg};
    // Error causes stay quiet while the status word already tells
    // the host, unless software asks for both.
    wire irq_raw = i_chan_irq | ((dna_reg | unf_reg | ovf_reg | bovf_reg)
                   & (~sten_reg | iws_reg));
    wire out_bit = (state_reg == S_DATA && !dir_reg)
                   ? tx_unit_reg[ub_last - bit_cnt_reg]
                   : (state_reg == S_STAT)
                   ? stat_w[5'h1f - bit_cnt_reg] : 1'b0;

    // ************************************************************
    // Port register read decode
    // ************************************************************
    always @* begin
        f0_rd = 8'h00;
        if (o_rd_addr == `WSSP_REG_CTRL) begin
            f0_rd = {wake_reg, 1'b0, pol_reg, hs_reg, 2'h0,
                     be_reg, wl_reg};
        end else if (o_rd_addr == `WSSP_REG_STCTL) begin
            f0_rd = {6'h00, iws_reg, sten_reg};
        end else if (o_rd_addr == `WSSP_REG_INT0) begin
            f0_rd = {bovf_reg, 1'b0, i_pkt_waiting, 2'h0,
                     ovf_reg, unf_reg, dna_reg};
        end else if (o_rd_addr >= `WSSP_REG_PAT &&
                     o_rd_addr <= `WSSP_REG_PAT_END) begin
            f0_rd = P_PATTERN[{o_rd_addr[1:0], 3'h0} +: 8];
        end
    end

    // ************************************************************
    // Main sequencer
    // ************************************************************
    always @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            sclk_d_reg    <= 1'b0;
            cs_d_reg      <= 1'b1;
            rise_d_reg    <= 1'b0;
            state_reg     <= S_IDLE;
            bit_cnt_reg   <= 5'h00;
            sh_reg        <= 32'h00000000;
            dir_reg       <= 1'b0;
            inc_reg       <= 1'b0;
            func_reg      <= 2'h0;
            ptr_reg       <= 17'h00000;
            byte_left_reg <= 12'h000;
            tx_unit_reg   <= 32'h00000000;
            nxt_unit_reg  <= 32'h00000000;
            em_unit_reg   <= 32'h00000000;
            em_cnt_reg    <= 3'h0;
            em_k_reg      <= 2'h0;
            fe_left_reg   <= 12'h000;
            fe_cnt_reg    <= 3'h0;
            fe_k_reg      <= 2'h0;
            fe_phase_reg  <= 1'b0;
            wl_reg        <= `WSSP_RST_WL;
            be_reg        <= `WSSP_RST_BE;
            hs_reg        <= `WSSP_RST_HS;
            pol_reg       <= `WSSP_RST_POL;
            wake_reg      <= 1'b0;
            sten_reg      <= `WSSP_RST_STEN;
            iws_reg       <= `WSSP_RST_IWS;
            dna_reg       <= 1'b0;
            unf_reg       <= 1'b0;
            ovf_reg       <= 1'b0;
            bovf_reg      <= 1'b0;
            x_dna_reg     <= 1'b0;
            x_unf_reg     <= 1'b0;
            x_ovf_reg     <= 1'b0;
            o_data0_sdo   <= 1'b0;
            o_data0_oe    <= 1'b0;
            o_data1_irq   <= 1'b0;
            o_wakeup      <= 1'b0;
            o_wr_valid    <= 1'b0;
            o_wr_func     <= 2'h0;
            o_wr_addr     <= 17'h00000;
            o_wr_data     <= 8'h00;
            o_rd_req      <= 1'b0;
            o_rd_func     <= 2'h0;
            o_rd_addr     <= 17'h00000;
        end else begin
            sclk_d_reg  <= sclk_s;
            cs_d_reg    <= cs_s;
            rise_d_reg  <= rise;
            o_wr_valid  <= 1'b0;
            o_rd_req    <= 1'b0;
            o_wakeup    <= 1'b0;
            o_data0_oe  <= ~cs_s;
            o_data1_irq <= pol_reg ? irq_raw : ~irq_raw;

            // Read prefetch: request, then capture one cycle later
            if (fe_cnt_reg != 3'h0) begin
                if (!fe_phase_reg) begin
                    o_rd_req     <= ~is_port;
                    o_rd_func    <= func_reg;
                    o_rd_addr    <= ptr_reg;
                    fe_phase_reg <= 1'b1;
                end else begin
                    nxt_unit_reg[{fe_i, 3'h0} +: 8] <= fe_byte;
                    if (!is_port && !i_rd_avail) begin
                        if (func_reg == `WSSP_FN_BACK)
                            x_dna_reg <= 1'b1;
                        else
                            x_unf_reg <= 1'b1;
                    end
                    ptr_reg      <= ptr_inc;
                    fe_cnt_reg   <= fe_cnt_reg - 3'h1;
                    fe_k_reg     <= fe_k_reg + 2'h1;
                    fe_phase_reg <= 1'b0;
                end
            end

            // Write emission, one byte per cycle in address order
            if (em_cnt_reg != 3'h0) begin
                if (is_port) begin
                    if (ptr_reg == `WSSP_REG_CTRL) begin
                        wl_reg   <= em_byte[`WSSP_CTRL_WL];
                        be_reg   <= em_byte[`WSSP_CTRL_BE];
                        hs_reg   <= em_byte[`WSSP_CTRL_HS];
                        pol_reg  <= em_byte[`WSSP_CTRL_POL];
                        wake_reg <= em_byte[`WSSP_CTRL_WAKE];
                        o_wakeup <= em_byte[`WSSP_CTRL_WAKE];
                    end else if (ptr_reg == `WSSP_REG_STCTL) begin
                        sten_reg <= em_byte[`WSSP_STCTL_STEN];
                        iws_reg  <= em_byte[`WSSP_STCTL_IWS];
                    end else if (ptr_reg == `WSSP_REG_INT0) begin
                        if (em_byte[`WSSP_INT_DNA])
                            dna_reg <= 1'b0;
                    end
                end else begin
                    o_wr_valid <= 1'b1;
                    o_wr_func  <= func_reg;
                    o_wr_addr  <= ptr_reg;
                    o_wr_data  <= em_byte;
                    if (i_wr_full)
                        x_ovf_reg <= 1'b1;
                end
                ptr_reg    <= ptr_inc;
                em_cnt_reg <= em_cnt_reg - 3'h1;
                em_k_reg   <= em_k_reg + 2'h1;
            end

            // Frame control: each select low is a fresh command
            if (cs_s) begin
                state_reg  <= S_IDLE;
                fe_cnt_reg <= 3'h0;
            end else if (cs_fall) begin
                state_reg   <= S_CMD;
                bit_cnt_reg <= 5'h00;
                x_dna_reg   <= 1'b0;
                x_unf_reg   <= 1'b0;
                x_ovf_reg   <= 1'b0;
            end else if (rise) begin
                // Host sets up each bit ahead of this edge
                sh_reg      <= cmd_w;
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                case (state_reg)
                    S_CMD: begin
                        if (bit_cnt_reg == `WSSP_ADDR_LAST) begin
                            // Address known: prefetch the first unit
                            dir_reg  <= early_w[`WSSP_CMD_DIR];
                            inc_reg  <= early_w[`WSSP_CMD_INC];
                            func_reg <= early_w[`WSSP_CMD_FN_HI:
                                                `WSSP_CMD_FN_LO];
                            ptr_reg  <= early_w[`WSSP_CMD_AD_HI:
                                                `WSSP_CMD_AD_LO];
                            if (!early_w[`WSSP_CMD_DIR]) begin
                                fe_cnt_reg   <= nb;
                                fe_k_reg     <= 2'h0;
                                fe_phase_reg <= 1'b0;
                            end
                        end
                        if (bit_cnt_reg == `WSSP_CMD_LAST) begin
                            state_reg     <= S_DATA;
                            bit_cnt_reg   <= 5'h00;
                            byte_left_reg <= tot_w;
                            if (!dir_reg) begin
                                // First bit launched from this edge when hs_reg is set, else from the next fall
                                tx_unit_reg  <= nxt_unit_reg;
                                fe_cnt_reg   <= take0[2:0];
                                fe_left_reg  <= rem0 - take0;
                                fe_k_reg     <= 2'h0;
                                fe_phase_reg <= 1'b0;
                            end
                        end
                    end
                    S_DATA: begin
                        if (bit_cnt_reg == ub_last) begin
                            bit_cnt_reg <= 5'h00;
                            if (dir_reg) begin
                                em_unit_reg <= cmd_w;
                                em_cnt_reg  <= em_take[2:0];
                                em_k_reg    <= 2'h0;
                            end else begin
                                tx_unit_reg  <= nxt_unit_reg;
                                fe_cnt_reg   <= fe_take[2:0];
                                fe_left_reg  <= fe_left_reg - fe_take;
                                fe_k_reg     <= 2'h0;
                                fe_phase_reg <= 1'b0;
                            end
                            if (byte_left_reg <= nb12) begin
                                byte_left_reg <= 12'h000;
                                // No status costs no extra clocks
                                state_reg <= sten_reg ? S_STAT
                                             : S_DONE;
                            end else begin
                                byte_left_reg <= byte_left_reg - nb12;
                            end
                        end
                    end
                    S_STAT: begin
                        if (bit_cnt_reg == `WSSP_CMD_LAST)
                            state_reg <= S_DONE;
                    end
                    default: begin
                        bit_cnt_reg <= bit_cnt_reg;
                    end
                endcase
            end

            // Serial output on the selected edge, host samples rising
            if (cs_s)
                o_data0_sdo <= 1'b0;
            else if (drive)
                o_data0_sdo <= out_bit;

            // Last-transfer flags; a new set beats a clear
            if (commit) begin
                if (dir_reg) begin
                    ovf_reg  <= x_ovf_reg & (func_reg != `WSSP_FN_BACK);
                    bovf_reg <= x_ovf_reg & (func_reg == `WSSP_FN_BACK);
                end else begin
                    unf_reg <= x_unf_reg;
                end
                if (x_dna_reg)
                    dna_reg <= 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

//--- hdl/wssp_defines.vh
// Constants of the serial host slave port: fields, registers, status bits
`ifndef WSSP_DEFINES_VH
`define WSSP_DEFINES_VH

// Command word field positions
`define WSSP_CMD_DIR      31
`define WSSP_CMD_INC      30
`define WSSP_CMD_FN_HI    29
`define WSSP_CMD_FN_LO    28
`define WSSP_CMD_AD_HI    27
`define WSSP_CMD_AD_LO    11
`define WSSP_CMD_LN_HI    10
`define WSSP_CMD_LN_LO    0
`define WSSP_CMD_LAST     5'h1f
`define WSSP_ADDR_LAST    5'h14
`define WSSP_LEN_MAX      12'h800

// Function codes
`define WSSP_FN_PORT      2'h0
`define WSSP_FN_BACK      2'h1
`define WSSP_FN_PKT1      2'h2
`define WSSP_FN_PKT2      2'h3

// Port register byte addresses
`define WSSP_REG_CTRL     17'h00000
`define WSSP_REG_STCTL    17'h00002
`define WSSP_REG_INT0     17'h00004
`define WSSP_REG_PAT      17'h00014
`define WSSP_REG_PAT_END  17'h00017

// Control register bits and reset values
`define WSSP_CTRL_WL      0
`define WSSP_CTRL_BE      1
`define WSSP_CTRL_HS      4
`define WSSP_CTRL_POL     5
`define WSSP_CTRL_WAKE    7
`define WSSP_RST_WL       1'h0
`define WSSP_RST_BE       1'h0
`define WSSP_RST_HS       1'h1
`define WSSP_RST_POL      1'h1
`define WSSP_STCTL_STEN   0
`define WSSP_STCTL_IWS    1
`define WSSP_RST_STEN     1'h1
`define WSSP_RST_IWS      1'h0

// Interrupt register bits
`define WSSP_INT_DNA      0
`define WSSP_INT_UNF      1
`define WSSP_INT_OVF      2
`define WSSP_INT_PKTW     5
`define WSSP_INT_BOVF     7

// Status word bits
`define WSSP_ST_DNA       0
`define WSSP_ST_UNF       1
`define WSSP_ST_OVF       2
`define WSSP_ST_CIRQ      3
`define WSSP_ST_EMPTY     4
`define WSSP_ST_PKTW      8
`define WSSP_ST_LEN_LO    9
`define WSSP_ST_LEN_HI    19

// Readiness pattern, value is arbitrary
`define WSSP_PATTERN      32'hfeedbead

`endif

//--- hdl/wssp_sync.v
// Two-flop synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
`default_nettype none

module wssp_sync #(
    parameter         P_W   = 1,
    parameter [P_W-1:0] P_RST = {P_W{1'b0}}
) (
    input  wire           i_clk,
    input  wire           i_rst,
    input  wire [P_W-1:0] i_d,
    output reg  [P_W-1:0] o_q
);

    reg [P_W-1:0] meta_reg;

    // The first stage is read by the second stage only
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_reg <= P_RST;
            o_q      <= P_RST;
        end else begin
            meta_reg <= i_d;
            o_q      <= meta_reg;
        end
    end

endmodule

`default_nettype wire

//--- verification/wssp_host_model.sv
// Host model: bus master driving chip select, serial clock and data in
`timescale 1ns/1ps
`default_nettype none

module wssp_host_model (
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end

    // ****************************************
    // Frame: command, data, status
    // ****************************************
    // Clock stands low between frames; 80 ns phases give the sampler room
    task automatic frame(input logic [31:0] cmd, input logic [31:0] wd,
                         input int nb, output logic [31:0] rd,
                         output logic [31:0] st);
        logic [63:0] bits;
        bits = {cmd, wd};
        rd = 32'h0;
        st = 32'h0;
        o_cs_n = 1'b0;
        o_sdi = bits[63];
        #80;
        for (int r = 1; r <= 64 + nb; r++) begin
            o_sclk = 1'b1;
            if (r > 32 + nb) st = {st[30:0], i_sdo};
            else if (r > 32) rd = {rd[30:0], i_sdo};
            #80;
            o_sclk = 1'b0;
            // Idle data toggles so a stale level cannot pass for data
            if (r < 32 || (cmd[31] && r < 32 + nb))
                o_sdi = bits[63 - r];
            else
                o_sdi = ~o_sdi;
            #80;
        end
        o_cs_n = 1'b1;
        #400;
    endtask
endmodule

`default_nettype wire

//--- verification/wssp_slave_assertions.sv
// Checker of the serial host slave port, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module wssp_slave_assertions (
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_data3_cs_n,
    input wire logic       o_data0_sdo,
    input wire logic       o_data0_oe,
    input wire logic       o_wakeup,
    input wire logic       o_wr_valid,
    input wire logic [1:0] o_wr_func,
    input wire logic       o_rd_req,
    input wire logic [1:0] o_rd_func
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_off_deselect:
        assert property (i_data3_cs_n [*4] |-> !o_data0_oe && !o_data0_sdo)
        else $error("data out active while deselected");
    a_on_select:
        assert property (!i_data3_cs_n [*4] |-> o_data0_oe)
        else $error("data out not enabled while selected");
    a_wr_func_route:
        assert property (o_wr_valid |-> o_wr_func != 2'h0)
        else $error("user write issued for port registers");
    a_rd_func_route:
        assert property (o_rd_req |-> o_rd_func != 2'h0)
        else $error("user read issued for port registers");
    a_rd_spacing:
        assert property (o_rd_req |=> !o_rd_req)
        else $error("read requests closer than two clocks");
    a_wr_unit_func:
        assert property (o_wr_valid && $past(o_wr_valid)
                         |-> o_wr_func == $past(o_wr_func))
        else $error("function changed within a unit");
    a_idle_no_access:
        assert property (i_data3_cs_n [*8] |-> !o_wr_valid && !o_rd_req)
        else $error("user access while deselected");
    a_wake_pulse:
        assert property (o_wakeup |=> !o_wakeup)
        else $error("wake pulse longer than one clock");
endmodule

bind wssp_slave wssp_slave_assertions wssp_slave_assertions_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_data3_cs_n(i_data3_cs_n),
    .o_data0_sdo(o_data0_sdo), .o_data0_oe(o_data0_oe),
    .o_wakeup(o_wakeup), .o_wr_valid(o_wr_valid), .o_wr_func(o_wr_func),
    .o_rd_req(o_rd_req), .o_rd_func(o_rd_func));

`default_nettype wire

//--- verification/wssp_slave_test.sv
// Self-checking bench for the serial host slave port
`timescale 1ns/1ps
`default_nettype none

module wssp_slave_test;
    typedef struct {
        logic [31:0] cmd;
        logic [31:0] wd;
        int          nb;
        logic [3:0]  ctl;
        logic [31:0] ed;
        logic [31:0] es;
    } wssp_row_t;
    // Status with fifo empty, packet waiting and waiting length 0x123
    localparam logic [31:0] stb = 32'h00024710;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        av = 1'b1;
    logic        full = 1'b0;
    logic        cirq = 1'b0;
    logic        sclk, cs_n, sdi, sdo, oe, irq, wake, wr_v, rd_req;
    logic [1:0]  wr_fn, rd_fn;
    logic [16:0] wr_ad, rd_ad;
    logic [7:0]  wr_d;
    logic [31:0] rd, st;
    logic [26:0] wq[$];
    int          failures = 0;
    int          n_checks = 0;
    int          nwake = 0;
    int          cyc = 0;
    wssp_row_t   rows[13];
    wire         sdo_pin = oe ? sdo : sclk;

    always #10 clk = ~clk;

    wssp_slave wssp_slave_i (
        .i_clk_sys(clk), .i_rst(rst), .i_serial_clock_pin(sclk),
        .i_data3_cs_n(cs_n), .i_cmd_sdi(sdi), .o_data0_sdo(sdo),
        .o_data0_oe(oe), .o_data1_irq(irq), .o_wakeup(wake),
        .o_wr_valid(wr_v), .o_wr_func(wr_fn), .o_wr_addr(wr_ad),
        .o_wr_data(wr_d), .i_wr_full(full), .o_rd_req(rd_req),
        .o_rd_func(rd_fn), .o_rd_addr(rd_ad), .i_rd_data(rd_ad[7:0]),
        .i_rd_avail(av), .i_chan_irq(cirq), .i_pkt_fifo_empty(1'b1),
        .i_pkt_waiting(1'b1), .i_pkt_len(11'h123));
    wssp_host_model wssp_host_model_i (
        .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_sdo(sdo_pin));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] mk(input logic [3:0] h,
                                       input logic [16:0] a,
                                       input logic [10:0] n);
        return {h, a, n};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wr_v === 1'b1) wq.push_back({wr_fn, wr_ad, wr_d});
        if (wake === 1'b1) nwake <= nwake + 1;
        // Fourteen frames need about 10100 clocks
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    // ctl: avail, full, check status, check data
    initial begin
        rows = '{
            '{mk(4'h4, 17'h14, 11'h4), 0, 32, 4'hb,
              32'hbeadfeed, stb},
            '{mk(4'h5, 17'h40, 11'h2), 0, 16, 4'hb,
              32'h4140, stb},
            '{mk(4'h1, 17'h40, 11'h2), 0, 16, 4'hb,
              32'h4040, stb},
            '{mk(4'h3, 17'h07, 11'h2), 0, 16, 4'hb,
              32'h0707, stb},
            '{mk(4'h5, 17'h40, 11'h2), 0, 16, 4'h3,
              0, stb | 32'h1},
            '{mk(4'h6, 17'h00, 11'h2), 0, 16, 4'h3,
              0, stb | 32'h2},
            '{mk(4'he, 17'h10, 11'h2), 32'habcd0000, 16, 4'h6, 0,
              stb | 32'h4},
            '{mk(4'hc, 17'h0, 11'h1), 32'h00b00000, 16, 4'h8,
              0, 0},
            '{mk(4'hc, 17'h0, 11'h1), 32'h00230000, 16, 4'h8,
              0, 0},
            '{mk(4'h4, 17'h14, 11'h4), 0, 32, 4'hb,
              32'hadbeedfe, stb},
            '{mk(4'h5, 17'h40, 11'h4), 0, 32, 4'hb,
              32'h40414243, stb},
            '{mk(4'hc, 17'h02, 11'h1), 0, 32, 4'h8,
              0, 0},
            '{mk(4'h5, 17'h40, 11'h4), 0, 32, 4'hb,
              32'h40414243, 0}};
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        tick(4);
        check({28'h0, oe, sdo, irq, wake}, 32'h0);
        foreach (rows[i]) begin
            tick(1);
            av = rows[i].ctl[3];
            full = rows[i].ctl[2];
            wssp_host_model_i.frame(rows[i].cmd, rows[i].wd, rows[i].nb,
                                    rd, st);
            if (rows[i].ctl[0]) check(rd, rows[i].ed);
            if (rows[i].ctl[1]) check(st, rows[i].es);
        end
        check(32'(wq.size()), 32'h2);
        check(32'(wq[0]), {5'h0, 2'h2, 17'h10, 8'hcd});
        check(32'(wq[1]), {5'h0, 2'h2, 17'h11, 8'hab});
        check(32'(nwake), 32'h1);
        // Data-not-available is still pending and status is now off
        tick(1);
        check({31'h0, irq}, 32'h1);
        wssp_host_model_i.frame(mk(4'hc, 17'h04, 11'h1), 32'h01000000, 32,
                                rd, st);
        tick(1);
        check({31'h0, irq}, 32'h0);
        cirq = 1'b1;
        tick(8);
        check({31'h0, irq}, 32'h1);
        cirq = 1'b0;
        tick(8);
        check({31'h0, irq}, 32'h0);
        stop_test();
    end
endmodule

`default_nettype wire
